// *** rtl/thgo_mem.sv ***
// Two-bank word buffer with registered read data
`timescale 1ns/1ps
module thgo_mem
  import thgo_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              wr_en,
  input  wire logic [MEM_AW-1:0] wr_addr,
  input  wire logic [WORD_W-1:0] wr_data,
  input  wire logic              rd_en,
  input  wire logic [MEM_AW-1:0] rd_addr,
  output logic      [WORD_W-1:0] rd_data
);

  logic [WORD_W-1:0] mem_reg [0:(1<<MEM_AW)-1];

  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rd_en)
    begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule : thgo_mem

// *** rtl/thgo_pkg.sv ***
// Package: constants and carrier types of the health-gated random output stage
package thgo_pkg;

  // ****************************************
  // Word format
  // ****************************************
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned BYTE_W    = 8;
  localparam logic [4:0]  WORD_LAST = 5'h0F;
  localparam logic [4:0]  BYTE_LAST = 5'h07;

  // ****************************************
  // Online test window and bounds
  // ****************************************
  localparam int unsigned WIN_W      = 7;
  localparam logic [6:0]  WIN_LAST   = 7'h7F;        // 128 raw bits per window
  localparam logic [7:0]  ONES_MIN   = 8'h2C;        // 44 ones
  localparam logic [7:0]  ONES_MAX   = 8'h54;        // 84 ones
  localparam logic [4:0]  WORDS_16   = 5'h08;        // words per window, 16-bit
  localparam logic [4:0]  WORDS_8    = 5'h10;        // words per window, 8-bit

  // ****************************************
  // Total failure test
  // ****************************************
  localparam logic [5:0]  TF_RUN_MAX = 6'h20;        // identical bits in a row

  // ****************************************
  // Buffer memory
  // ****************************************
  localparam int unsigned MEM_AW = 5;                // two banks of 16 words
  localparam int unsigned IDX_W  = 4;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic              valid;
    logic              is_16;
    logic [WORD_W-1:0] data;
  } thgo_word_t;

  typedef struct packed {
    logic startup_done;
    logic total_fail;
    logic stat_fail;
  } thgo_health_t;

endpackage : thgo_pkg

// *** rtl/thgo_top.sv ***
// Health-gated output stage of a physical random number generator
`timescale 1ns/1ps
module thgo_top
  import thgo_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   sys_rst,
  input  wire logic   raw_bit,
  input  wire logic   raw_valid,
  input  wire logic   width_16,
  input  wire logic   stat_fail_clr,
  input  wire logic   rnd_ready,
  output thgo_word_t  rnd_out,
  output thgo_health_t health
);

  // ****************************************
  // State
  // ****************************************
  logic [5:0]        run_cnt_reg;
  logic              last_bit_reg;
  logic              tf_reg;
  logic [WIN_W-1:0]  win_cnt_reg;
  logic [7:0]        ones_cnt_reg;
  logic              stat_fail_reg;
  logic              startup_done_reg;
  logic              collect_reg;
  logic              is16_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [4:0]        bit_cnt_reg;
  logic [IDX_W-1:0]  wr_idx_reg;
  logic              fill_bank_reg;
  logic [4:0]        rd_cnt_reg;
  logic [IDX_W-1:0]  rd_idx_reg;
  logic              rd_is16_reg;
  logic              pend_reg;
  thgo_word_t        out_reg;

  logic [7:0]        ones_total;
  logic              win_end;
  logic              win_pass;
  logic              win_fail;
  logic              tf_hit;
  logic              flush;
  logic              win_start;
  logic              collect_now;
  logic              word_done;
  logic [WORD_W-1:0] shift_next;
  logic              rd_issue;
  logic [WORD_W-1:0] mem_rd_data;

  assign ones_total = ones_cnt_reg + {7'h00, raw_bit};
  assign win_end    = raw_valid && (win_cnt_reg == WIN_LAST);
  assign win_pass   = win_end && (ones_total >= ONES_MIN) && (ones_total <= ONES_MAX);
  assign win_fail   = win_end && !win_pass;
  assign tf_hit     = raw_valid && (raw_bit == last_bit_reg) &&
                      (run_cnt_reg == TF_RUN_MAX - 6'h01);
  assign flush      = tf_hit || tf_reg || win_fail;
  assign shift_next = {shift_reg[WORD_W-2:0], raw_bit};
  assign win_start   = raw_valid && (win_cnt_reg == '0);
  // First bit of a window already belongs to its first word
  assign collect_now = collect_reg ||
                       (win_start && (rd_cnt_reg == 5'h00) && !stat_fail_reg && !stat_fail_clr);
  assign word_done  = raw_valid && collect_now &&
                      (bit_cnt_reg == (is16_reg ? WORD_LAST : BYTE_LAST));
  assign rd_issue   = !flush && !pend_reg && !out_reg.valid && (rd_cnt_reg != 5'h00);

  // ****************************************
  // Total failure test
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_cnt_reg  <= 6'h00;
      last_bit_reg <= 1'b0;
    end
    else if (raw_valid)
    begin
      last_bit_reg <= raw_bit;
      if ((raw_bit == last_bit_reg) && (run_cnt_reg != TF_RUN_MAX))
      begin
        run_cnt_reg <= run_cnt_reg + 6'h01;
      end
      else if (raw_bit != last_bit_reg)
      begin
        run_cnt_reg <= 6'h01;
      end
    end
  end

  // Latched until reset: a dead source cannot be trusted to come back
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tf_reg <= 1'b0;
    end
    else if (tf_hit)
    begin
      tf_reg <= 1'b1;
    end
  end

  // ****************************************
  // Online test, back-to-back windows
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      win_cnt_reg  <= '0;
      ones_cnt_reg <= 8'h00;
    end
    else if (raw_valid)
    begin
      win_cnt_reg  <= win_cnt_reg + 7'h01;
      ones_cnt_reg <= win_end ? 8'h00 : ones_total;
    end
  end

  // Set wins over clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stat_fail_reg <= 1'b0;
    end
    else if (win_fail)
    begin
      stat_fail_reg <= 1'b1;
    end
    else if (stat_fail_clr)
    begin
      stat_fail_reg <= 1'b0;
    end
  end

  // After a defect the start-up pass must be earned again
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      startup_done_reg <= 1'b0;
    end
    else if (flush)
    begin
      startup_done_reg <= 1'b0;
    end
    else if (win_pass && collect_reg)
    begin
      startup_done_reg <= 1'b1;
    end
  end

  // ****************************************
  // Word assembly into the fill bank
  // ****************************************
  // A window is collected only if the read bank is empty at its start,
  // so raw bits are dropped rather than stalling the source.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      collect_reg <= 1'b0;
      is16_reg    <= 1'b0;
    end
    else if (flush || win_end)
    begin
      collect_reg <= 1'b0;
    end
    else if (win_start)
    begin
      collect_reg <= collect_now;
      is16_reg    <= width_16;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_reg   <= '0;
      bit_cnt_reg <= 5'h00;
      wr_idx_reg  <= '0;
    end
    else if (flush || !collect_now)
    begin
      bit_cnt_reg <= 5'h00;
      wr_idx_reg  <= '0;
    end
    else if (raw_valid)
    begin
      shift_reg   <= shift_next;
      bit_cnt_reg <= word_done ? 5'h00 : bit_cnt_reg + 5'h01;
      wr_idx_reg  <= wr_idx_reg + {3'h0, word_done};
    end
  end

  // ****************************************
  // Bank release on a passing window
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fill_bank_reg <= 1'b0;
      rd_cnt_reg    <= 5'h00;
      rd_idx_reg    <= '0;
      rd_is16_reg   <= 1'b0;
    end
    else if (flush)
    begin
      rd_cnt_reg <= 5'h00;
    end
    else if (win_pass && collect_reg)
    begin
      fill_bank_reg <= !fill_bank_reg;
      rd_cnt_reg    <= is16_reg ? WORDS_16 : WORDS_8;
      rd_idx_reg    <= '0;
      rd_is16_reg   <= is16_reg;
    end
    else if (rd_issue)
    begin
      rd_cnt_reg <= rd_cnt_reg - 5'h01;
      rd_idx_reg <= rd_idx_reg + 4'h1;
    end
  end

  thgo_mem thgo_mem_inst (
    .mclk    (mclk),
    .wr_en   (word_done && !flush),
    .wr_addr ({fill_bank_reg, wr_idx_reg}),
    .wr_data (is16_reg ? shift_next : {8'h00, shift_next[BYTE_W-1:0]}),
    .rd_en   (rd_issue),
    .rd_addr ({!fill_bank_reg, rd_idx_reg}),
    .rd_data (mem_rd_data)
  );

  // ****************************************
  // Output register
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_reg <= 1'b0;
      out_reg  <= '0;
    end
    else if (flush)
    begin
      pend_reg      <= 1'b0;
      out_reg.valid <= 1'b0;
    end
    else
    begin
      pend_reg <= rd_issue;
      if (pend_reg)
      begin
        out_reg.valid <= 1'b1;
        out_reg.is_16 <= rd_is16_reg;
        out_reg.data  <= mem_rd_data;
      end
      else if (rnd_ready)
      begin
        out_reg.valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      health <= '0;
    end
    else
    begin
      health.startup_done <= startup_done_reg;
      health.total_fail   <= tf_reg || tf_hit;
      health.stat_fail    <= stat_fail_reg || win_fail;
    end
  end

  assign rnd_out = out_reg;

endmodule : thgo_top

// *** verification/thgo_assertions.sv ***
// Checker: port-level assertions of the health-gated output stage
`timescale 1ns/1ps
module thgo_checker
  import thgo_pkg::*;
(
  input wire logic   mclk,
  input wire logic   sys_rst,
  input wire logic   raw_valid,
  input wire logic   stat_fail_clr,
  input wire logic   rnd_ready,
  input thgo_word_t  rnd_out,
  input thgo_health_t health
);
  // ****************************************
  // Raw bit count since reset
  // ****************************************
  logic [7:0] bits_reg;
  // Saturates so later windows still see a full count
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      bits_reg <= 8'h00;
    else if (raw_valid && bits_reg != 8'hFF)
      bits_reg <= bits_reg + 8'h01;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_tf_blocks_out: assert property (health.total_fail && $past(health.total_fail)
    |-> !rnd_out.valid) else $error("word out after total failure");
  a_tf_stays_set: assert property (health.total_fail |=> health.total_fail)
    else $error("total failure flag cleared");
  a_window_first: assert property ($rose(health.startup_done) |-> bits_reg >= 8'h80)
    else $error("startup passed before a full window");
  a_no_early_out: assert property (!health.startup_done && !$past(health.startup_done)
    |-> !rnd_out.valid) else $error("word out before startup passed");
  a_defect_blocks: assert property (health.stat_fail && $past(health.stat_fail)
    |-> !rnd_out.valid) else $error("word out during online defect");
  a_byte_high_zero: assert property (rnd_out.valid && !rnd_out.is_16
    |-> rnd_out.data[15:8] == 8'h00) else $error("byte word has high bits");
  a_take_gap: assert property (rnd_out.valid && rnd_ready |=> !rnd_out.valid [*2])
    else $error("next word too soon");
  a_word_holds: assert property (rnd_out.valid && !rnd_ready
    |=> !rnd_out.valid || $stable(rnd_out)) else $error("word changed while held");
  a_defect_sticky: assert property (health.stat_fail && !stat_fail_clr
    && !$past(stat_fail_clr) |=> health.stat_fail)
    else $error("defect flag lost without clear");
endmodule : thgo_checker

bind thgo_top thgo_checker thgo_checker_inst (.mclk(mclk), .sys_rst(sys_rst),
  .raw_valid(raw_valid), .stat_fail_clr(stat_fail_clr), .rnd_ready(rnd_ready),
  .rnd_out(rnd_out), .health(health));

// *** verification/thgo_consumer.sv ***
// Consumer model: takes random words, stalls on command
`timescale 1ns/1ps
module thgo_consumer
  import thgo_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire thgo_word_t  rnd_out,
  input  wire logic        stall,
  output logic             rnd_ready,
  output logic [7:0]       taken,
  output logic [WORD_W-1:0] last_data
);
  assign rnd_ready = !stall;
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      taken     <= 8'h00;
      last_data <= 16'h0000;
    end
    else if (rnd_out.valid && rnd_ready)
    begin
      taken     <= taken + 8'h01;
      last_data <= rnd_out.data;
    end
endmodule : thgo_consumer

// *** verification/thgo_top_tb_top.sv ***
// Testbench: startup gating, widths, online defect and total failure
`timescale 1ns/1ps
module thgo_top_tb_top;
  import thgo_pkg::*;
  logic         mclk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         raw_bit = 1'b0;
  logic         raw_valid = 1'b0;
  logic         width_16 = 1'b1;
  logic         stat_fail_clr = 1'b0;
  logic         stall = 1'b1;
  logic         rnd_ready;
  logic [7:0]   taken;
  logic [15:0]  last_data;
  thgo_word_t   rnd_out;
  thgo_health_t health;
  int           fails = 0;
  int           checks = 0;

  thgo_top thgo_top_inst (.mclk(mclk), .sys_rst(sys_rst), .raw_bit(raw_bit),
    .raw_valid(raw_valid), .width_16(width_16), .stat_fail_clr(stat_fail_clr),
    .rnd_ready(rnd_ready), .rnd_out(rnd_out), .health(health));
  thgo_consumer thgo_consumer_inst (.mclk(mclk), .sys_rst(sys_rst), .rnd_out(rnd_out),
    .stall(stall), .rnd_ready(rnd_ready), .taken(taken), .last_data(last_data));

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim;
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Repeats a 4-bit pattern, first bit is the pattern MSB
  task automatic feed(input logic [3:0] pat, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge mclk);
      raw_valid = 1'b1;
      raw_bit   = pat[3 - (i % 4)];
    end
    @(negedge mclk);
    raw_valid = 1'b0;
  endtask : feed

  task automatic wait_words(input logic [7:0] n);
    for (int i = 0; i < 600 && taken !== n; i++)
      @(negedge mclk);
    chk("words taken", {8'h00, n}, {8'h00, taken});
  endtask : wait_words

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_startup;
    feed(4'hA, 127);
    chk("startup early", 16'h0000, {15'h0000, health.startup_done});
    chk("valid early", 16'h0000, {15'h0000, rnd_out.valid});
    feed(4'hA, 1);
    repeat (10) @(negedge mclk);
    chk("startup done", 16'h0001, {15'h0000, health.startup_done});
    chk("held word", 16'hAAAA, rnd_out.data);
    chk("held width", 16'h0001, {15'h0000, rnd_out.is_16});
    stall = 1'b0;
    wait_words(8'h08);
    chk("last word", 16'hAAAB, last_data);
  endtask : s_startup

  task automatic s_width8;
    width_16 = 1'b0;
    stall    = 1'b1;
    feed(4'hA, 128);
    repeat (10) @(negedge mclk);
    chk("byte held width", 16'h0000, {15'h0000, rnd_out.is_16});
    chk("byte held word", 16'h00AA, rnd_out.data);
    stall = 1'b0;
    wait_words(8'h18);
    chk("byte word", 16'h00AA, last_data);
    width_16 = 1'b1;
  endtask : s_width8

  task automatic s_defect;
    feed(4'h1, 128);
    repeat (40) @(negedge mclk);
    chk("defect flag", 16'h0001, {15'h0000, health.stat_fail});
    chk("startup cleared", 16'h0000, {15'h0000, health.startup_done});
    chk("words in defect", 16'h0018, {8'h00, taken});
    stat_fail_clr = 1'b1;
    @(negedge mclk);
    stat_fail_clr = 1'b0;
    @(negedge mclk);
    chk("defect cleared", 16'h0000, {15'h0000, health.stat_fail});
    feed(4'hA, 128);
    wait_words(8'h20);
  endtask : s_defect

  // A stuck source mid-window: nothing more may leave
  task automatic s_total;
    feed(4'hA, 64);
    feed(4'h0, 32);
    feed(4'hA, 160);
    repeat (40) @(negedge mclk);
    chk("total flag", 16'h0001, {15'h0000, health.total_fail});
    chk("words after stuck", 16'h0020, {8'h00, taken});
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    chk("total after reset", 16'h0000, {15'h0000, health.total_fail});
  endtask : s_total

  initial
  begin
    #100000;
    fails++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    s_startup();
    s_width8();
    s_defect();
    s_total();
    end_sim();
  end
endmodule : thgo_top_tb_top
